// ===== sol_pkg.sv
// startup option config loader: shared constants, enums and carrier structs
// assumes a single 25 MHz clock domain and a 32-bit AHB-Lite register bus
package sol_pkg;

  // ***************************************************
  // register map (byte addresses) and field layout
  // ***************************************************
  localparam logic [7:0] OFS_OPTIONS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_STORE_CFG = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam int OPT_W = 5;
  localparam int PAD_W = 6;
  localparam int IRQ_W = 3;
  localparam int IRQ_AWAIT = 0;
  localparam int IRQ_CORE = 1;
  localparam int IRQ_RSVD = 2;
  localparam int CFG_W = 3;
  localparam int CFG_CLK13 = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [CFG_W-1:0] STORE_CFG_RST = 3'h0;
  // pads 3..7 pull down, test environment select (bit 5) pulls up
  localparam logic [PAD_W-1:0] PULL_UP_MAP = 6'h20;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ***************************************************
  // enumerations
  // ***************************************************
  typedef enum logic [1:0] {
    MEM_NONE = 2'h0, MEM_RSVD = 2'h1, MEM_THREE_WIRE = 2'h2, MEM_TWO_WIRE = 2'h3
  } sol_mem_e;
  typedef enum logic [1:0] {CLK_12 = 2'h0, CLK_13 = 2'h1, CLK_DETECT = 2'h2} sol_clk_e;
  typedef enum logic [1:0] {
    BAUD_STORE = 2'h0, BAUD_9K6 = 2'h1, BAUD_115K2 = 2'h2, BAUD_921K6 = 2'h3
  } sol_baud_e;
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0, CMD_SET_CLK_BAUD = 2'h1, CMD_WRITE_ADDR = 2'h2, CMD_ENTER_MODE = 2'h3
  } sol_cmd_e;
  typedef enum logic [1:0] {BLK_PARAM = 2'h0, BLK_PATCH = 2'h1, BLK_STORE = 2'h2} sol_blk_e;
  typedef enum logic [9:0] {
    S_RESET = 10'h001, S_MEMSEL = 10'h002, S_LOAD_PARAM = 10'h004, S_LOAD_PATCH = 10'h008,
    S_LOAD_STORE = 10'h010, S_OPTIONS = 10'h020, S_AWAIT = 10'h040, S_WAIT_HOST = 10'h080,
    S_RETUNE = 10'h100, S_RUN = 10'h200
  } sol_state_e;

  // ***************************************************
  // carrier structs
  // ***************************************************
  typedef struct packed {
    sol_mem_e mem;
    sol_clk_e clk;
    sol_baud_e baud;
  } sol_strap_s;

  typedef struct packed {
    sol_state_e st;
    logic [OPT_W-1:0] opts;
    logic captured;
    logic addr_ok;
    logic cfg_ok;
    logic host_set;
    logic host_clk13;
    sol_baud_e host_baud;
    logic await;
    logic addr_wr;
    logic retune;
    logic clk13;
    sol_baud_e baud;
    logic started;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [CFG_W-1:0] store_cfg;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
  } sol_core_s;

endpackage

// ===== sol_sync.sv
// two flip-flop synchroniser for asynchronous pins
// assumes pins idle low during reset
`timescale 1ns/100ps
`default_nettype none
module sol_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in,              // system clock
  input wire logic rst_n_in,             // async reset, active low
  input wire logic [WIDTH-1:0] d_in,     // asynchronous pins
  output logic [WIDTH-1:0] q_out         // synchronised level
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  if (WIDTH < 1) begin : g_width_chk
    $error("sol_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule
`default_nettype wire

// ===== sol_strap_decode.sv
// decodes the captured option straps into memory, clock and rate settings
// assumes the options word holds pins three..seven in bits 0..4
`timescale 1ns/100ps
`default_nettype none
module sol_strap_decode (
  input wire logic [sol_pkg::OPT_W-1:0] opts_in,  // captured options
  output sol_pkg::sol_strap_s strap_out           // decoded settings
);
  logic [2:0] clk_code;

  always_comb begin
    strap_out.mem = sol_pkg::sol_mem_e'({opts_in[4], opts_in[3]});
    clk_code = {opts_in[0], opts_in[1], opts_in[2]};
    strap_out.clk = sol_pkg::CLK_13;
    strap_out.baud = sol_pkg::BAUD_STORE;
    unique case (clk_code)
      3'h0: strap_out.clk = sol_pkg::CLK_12;
      3'h4: strap_out.clk = sol_pkg::CLK_13;
      3'h5: strap_out.baud = sol_pkg::BAUD_9K6;
      3'h6: strap_out.baud = sol_pkg::BAUD_115K2;
      3'h7: strap_out.baud = sol_pkg::BAUD_921K6;
      default: strap_out.clk = sol_pkg::CLK_DETECT;
    endcase
  end
endmodule
`default_nettype wire

// ===== sol_loader.sv
// startup sequencer: strap capture, memory load, option evaluation, host
// configuration wait, serial port retune and protocol core start
// assumes memory engine and transport logic on mclk_in; reset pins and pads asynchronous
`timescale 1ns/100ps
`default_nettype none
module sol_loader (
  input wire logic mclk_in,                        // 25 MHz clock
  input wire logic rst_n_in,                       // async reset, active low
  input wire logic hsel_in,                        // ahb slave select
  input wire logic [31:0] haddr_in,                // ahb address
  input wire logic [1:0] htrans_in,                // ahb transfer type
  input wire logic hwrite_in,                      // ahb write
  input wire logic [2:0] hsize_in,                 // ahb size (word only)
  input wire logic [31:0] hwdata_in,               // ahb write data
  input wire logic hready_in,                      // ahb bus ready
  output logic [31:0] hrdata_out,                  // ahb read data
  output logic hreadyout_out,                      // ahb slave ready
  output logic hresp_out,                          // ahb response, okay
  output logic irq_out,                            // level interrupt
  input wire logic radio_reset_n_in,               // radio reset pin
  input wire logic baseband_reset_n_in,            // baseband reset pin
  input wire logic [sol_pkg::OPT_W-1:0] option_pin_in, // pins three..seven
  output logic [sol_pkg::PAD_W-1:0] strap_pull_en_out, // weak pulls on
  output logic [sol_pkg::PAD_W-1:0] strap_pull_up_out, // 1 up, 0 down
  output logic mem_load_req_out,                   // memory block load request
  output logic [1:0] mem_load_block_out,           // block being loaded
  output logic [1:0] mem_kind_out,                 // decoded memory kind
  input wire logic mem_load_done_in,               // block load done pulse
  input wire logic mem_addr_present_in,            // store has device address
  input wire logic mem_cfg_ok_in,                  // store config sufficient
  input wire logic host_cmd_valid_in,              // host command strobe
  input wire logic [1:0] host_cmd_in,              // host command code
  input wire logic [2:0] host_cmd_data_in,         // clk13 and rate code
  output logic await_init_out,                     // await-init event pulse
  output logic store_addr_write_out,               // save address pulse
  output logic uart_retune_out,                    // retune divisor pulse
  output logic uart_clk13_out,                     // baseband clock is 13 MHz
  output logic [1:0] uart_baud_out,                // rate code for divisor
  output logic core_start_out                      // protocol core running
);
  // ***************************************************
  // synchronisers and strap decode
  // ***************************************************
  logic [1:0] rst_pins;
  logic [sol_pkg::OPT_W-1:0] opt_sync;
  logic bb_prev;
  logic bb_rel;
  logic ra_rel;
  sol_pkg::sol_strap_s strap;
  sol_pkg::sol_core_s r;
  sol_pkg::sol_core_s nxt;
  logic addr_ph;
  logic cmd_enter;
  logic mem_fitted;
  logic need_host;
  logic [sol_pkg::IRQ_W-1:0] irq_set;

  sol_sync #(.WIDTH(2)) u_rst_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in({radio_reset_n_in, baseband_reset_n_in}),
    .q_out(rst_pins)
  );
  sol_sync #(.WIDTH(sol_pkg::OPT_W)) u_opt_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in(option_pin_in),
    .q_out(opt_sync)
  );
  sol_strap_decode u_decode (
    .opts_in(r.opts),
    .strap_out(strap)
  );

  assign ra_rel = rst_pins[1];
  assign bb_rel = rst_pins[0];
  assign addr_ph = hsel_in && hready_in && (htrans_in == sol_pkg::HTRANS_NONSEQ);
  assign cmd_enter = host_cmd_valid_in && (host_cmd_in == sol_pkg::CMD_ENTER_MODE);
  assign mem_fitted = (strap.mem == sol_pkg::MEM_THREE_WIRE) || (strap.mem == sol_pkg::MEM_TWO_WIRE);
  assign need_host = !mem_fitted || !r.addr_ok || !r.cfg_ok || (strap.clk == sol_pkg::CLK_DETECT);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bb_prev <= 1'b0;
    end else begin
      bb_prev <= bb_rel;
    end
  end

  // ***************************************************
  // next-state logic
  // ***************************************************
  always_comb begin
    nxt = r;
    irq_set = '0;
    nxt.await = 1'b0;
    nxt.addr_wr = 1'b0;
    nxt.retune = 1'b0;
    if (bb_rel && !bb_prev && !r.captured) begin
      nxt.opts = opt_sync;
      nxt.captured = 1'b1;
    end
    if (host_cmd_valid_in && (host_cmd_in == sol_pkg::CMD_SET_CLK_BAUD)) begin
      nxt.host_set = 1'b1;
      nxt.host_clk13 = host_cmd_data_in[2];
      nxt.host_baud = sol_pkg::sol_baud_e'(host_cmd_data_in[1:0]);
    end
    if (host_cmd_valid_in && (host_cmd_in == sol_pkg::CMD_WRITE_ADDR)) begin
      nxt.addr_ok = 1'b1;
      nxt.addr_wr = 1'b1;
    end
    unique case (r.st)
      sol_pkg::S_RESET: begin
        if (r.captured && ra_rel) begin
          nxt.st = sol_pkg::S_MEMSEL;
        end
      end
      sol_pkg::S_MEMSEL: begin
        if (strap.mem == sol_pkg::MEM_RSVD) begin
          irq_set[sol_pkg::IRQ_RSVD] = 1'b1;
        end
        nxt.st = mem_fitted ? sol_pkg::S_LOAD_PARAM : sol_pkg::S_OPTIONS;
      end
      sol_pkg::S_LOAD_PARAM: begin
        if (mem_load_done_in) begin
          nxt.st = sol_pkg::S_LOAD_PATCH;
        end
      end
      sol_pkg::S_LOAD_PATCH: begin
        if (mem_load_done_in) begin
          nxt.st = sol_pkg::S_LOAD_STORE;
        end
      end
      sol_pkg::S_LOAD_STORE: begin
        if (mem_load_done_in) begin
          nxt.addr_ok = mem_addr_present_in;
          nxt.cfg_ok = mem_cfg_ok_in;
          nxt.st = sol_pkg::S_OPTIONS;
        end
      end
      sol_pkg::S_OPTIONS: begin
        nxt.st = need_host ? sol_pkg::S_AWAIT : sol_pkg::S_RETUNE;
      end
      sol_pkg::S_AWAIT: begin
        nxt.await = 1'b1;
        irq_set[sol_pkg::IRQ_AWAIT] = 1'b1;
        nxt.st = sol_pkg::S_WAIT_HOST;
      end
      sol_pkg::S_WAIT_HOST: begin
        if (cmd_enter) begin
          nxt.st = sol_pkg::S_RETUNE;
        end
      end
      sol_pkg::S_RETUNE: begin
        if (strap.clk != sol_pkg::CLK_DETECT) begin
          nxt.clk13 = (strap.clk == sol_pkg::CLK_13);
        end else if (r.host_set) begin
          nxt.clk13 = r.host_clk13;
        end else begin
          nxt.clk13 = r.store_cfg[sol_pkg::CFG_CLK13];
        end
        if (strap.baud != sol_pkg::BAUD_STORE) begin
          nxt.baud = strap.baud;
        end else if (r.host_set) begin
          nxt.baud = r.host_baud;
        end else begin
          nxt.baud = sol_pkg::sol_baud_e'(r.store_cfg[1:0]);
        end
        nxt.retune = 1'b1;
        nxt.st = sol_pkg::S_RUN;
      end
      sol_pkg::S_RUN: begin
        if (!r.started) begin
          irq_set[sol_pkg::IRQ_CORE] = 1'b1;
        end
        nxt.started = 1'b1;
      end
      default: nxt.st = sol_pkg::S_RESET;
    endcase
    nxt.irq_stat = r.irq_stat | irq_set;
    // software side: data phase writes, w1c loses to a same-cycle set
    if (r.ph_wr) begin
      unique case (r.ph_addr)
        sol_pkg::OFS_IRQ_STAT: nxt.irq_stat = (r.irq_stat & ~hwdata_in[sol_pkg::IRQ_W-1:0]) | irq_set;
        sol_pkg::OFS_IRQ_MASK: nxt.irq_mask = hwdata_in[sol_pkg::IRQ_W-1:0];
        sol_pkg::OFS_STORE_CFG: nxt.store_cfg = hwdata_in[sol_pkg::CFG_W-1:0];
        default: nxt.ph_wr = 1'b0;
      endcase
    end
    nxt.ph_wr = addr_ph && hwrite_in;
    nxt.ph_addr = haddr_in[7:0];
    nxt.rdata = r.rdata;
    if (addr_ph && !hwrite_in) begin
      unique case (haddr_in[7:0])
        sol_pkg::OFS_OPTIONS: nxt.rdata = {27'h0, r.opts};
        sol_pkg::OFS_IRQ_STAT: nxt.rdata = {29'h0, r.irq_stat};
        sol_pkg::OFS_IRQ_MASK: nxt.rdata = {29'h0, r.irq_mask};
        sol_pkg::OFS_STORE_CFG: nxt.rdata = {29'h0, r.store_cfg};
        sol_pkg::OFS_STATE: nxt.rdata = {16'h0, strap.baud, strap.clk, strap.mem, r.st};
        default: nxt.rdata = 32'h0;
      endcase
    end
    // baseband reset reasserted: restart, pulls back on
    if (!bb_rel) begin
      nxt.st = sol_pkg::S_RESET;
      nxt.captured = 1'b0;
      nxt.started = 1'b0;
      nxt.addr_ok = 1'b0;
      nxt.cfg_ok = 1'b0;
      nxt.host_set = 1'b0;
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '{st: sol_pkg::S_RESET, host_baud: sol_pkg::BAUD_STORE, baud: sol_pkg::BAUD_STORE,
             irq_mask: sol_pkg::IRQ_MASK_RST, store_cfg: sol_pkg::STORE_CFG_RST, default: '0};
    end else begin
      r <= nxt;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign hrdata_out = r.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign irq_out = |(r.irq_stat & r.irq_mask);
  assign strap_pull_en_out = {sol_pkg::PAD_W{!r.captured}};
  assign strap_pull_up_out = sol_pkg::PULL_UP_MAP;
  assign mem_load_req_out = (r.st == sol_pkg::S_LOAD_PARAM) || (r.st == sol_pkg::S_LOAD_PATCH)
                            || (r.st == sol_pkg::S_LOAD_STORE);
  assign mem_load_block_out = (r.st == sol_pkg::S_LOAD_STORE) ? sol_pkg::BLK_STORE
                              : (r.st == sol_pkg::S_LOAD_PATCH) ? sol_pkg::BLK_PATCH : sol_pkg::BLK_PARAM;
  assign mem_kind_out = strap.mem;
  assign await_init_out = r.await;
  assign store_addr_write_out = r.addr_wr;
  assign uart_retune_out = r.retune;
  assign uart_clk13_out = r.clk13;
  assign uart_baud_out = r.baud;
  assign core_start_out = r.started;

  // ***************************************************
  // assertions
  // ***************************************************
  sequence s_retune;
    uart_retune_out ##1 core_start_out;
  endsequence
  sequence s_load_chain;
    (r.st == sol_pkg::S_LOAD_PATCH) && mem_load_done_in && bb_rel;
  endsequence

  property p_hold_opts;
    @(posedge mclk_in) disable iff (!rst_n_in) r.captured && $past(r.captured) |-> $stable(r.opts);
  endproperty
  a_hold_opts: assert property (p_hold_opts) else $error("options changed after capture");
  property p_read_opts;
    @(posedge mclk_in) disable iff (!rst_n_in)
      addr_ph && !hwrite_in && (haddr_in[7:0] == sol_pkg::OFS_OPTIONS) |=> hrdata_out == {27'h0, $past(r.opts)};
  endproperty
  a_read_opts: assert property (p_read_opts) else $error("options read wrong");
  property p_pulls;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (strap_pull_en_out != '0) == !r.captured && strap_pull_up_out == 6'h20;
  endproperty
  a_pulls: assert property (p_pulls) else $error("pull control wrong");
  property p_memsel;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (r.st == sol_pkg::S_MEMSEL) && bb_rel |=> (r.st == (mem_fitted ? sol_pkg::S_LOAD_PARAM : sol_pkg::S_OPTIONS));
  endproperty
  a_memsel: assert property (p_memsel) else $error("memory select branch wrong");
  property p_load_order;
    @(posedge mclk_in) disable iff (!rst_n_in) s_load_chain |=> (r.st == sol_pkg::S_LOAD_STORE);
  endproperty
  a_load_order: assert property (p_load_order) else $error("load order wrong");
  property p_opts_after_load;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (r.st == sol_pkg::S_OPTIONS) && mem_fitted |-> $past(r.st) == sol_pkg::S_LOAD_STORE;
  endproperty
  a_opts_after_load: assert property (p_opts_after_load) else $error("options before memory load");
  property p_no_mem_await;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (r.st == sol_pkg::S_OPTIONS) && !mem_fitted && bb_rel |-> ##2 await_init_out;
  endproperty
  a_no_mem_await: assert property (p_no_mem_await) else $error("await event missing");
  property p_wait;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (r.st == sol_pkg::S_WAIT_HOST) && !cmd_enter && bb_rel |=> r.st == sol_pkg::S_WAIT_HOST;
  endproperty
  a_wait: assert property (p_wait) else $error("left wait without command");
  property p_retune_first;
    @(posedge mclk_in) disable iff (!rst_n_in) $rose(core_start_out) |-> $past(uart_retune_out);
  endproperty
  a_retune_first: assert property (p_retune_first) else $error("core started before retune");
  property p_retune_start;
    @(posedge mclk_in) disable iff (!rst_n_in) uart_retune_out && bb_rel |-> s_retune;
  endproperty
  a_retune_start: assert property (p_retune_start) else $error("core not started after retune");
  property p_idle_core;
    @(posedge mclk_in) disable iff (!rst_n_in) (r.st != sol_pkg::S_RUN) |-> !core_start_out;
  endproperty
  a_idle_core: assert property (p_idle_core) else $error("core running early");
endmodule
`default_nettype wire

// ===== sol_host_model.sv
// partner model: serial memory engine and host controller facing the loader
// assumes the load request is a level and every strobe is sampled on mclk_in
`timescale 1ns/100ps
`default_nettype none
module sol_host_model #(
  parameter int RST_GAP = 20
) (
  input wire logic mclk_in,              // system clock
  input wire logic mem_load_req_in,      // load request level
  input wire logic [3:0] mem_dly_in,     // cycles before a block is done
  input wire logic addr_ok_in,           // store holds the device address
  input wire logic cfg_ok_in,            // store contents sufficient
  output logic mem_load_done_out,        // block done pulse
  output logic mem_addr_present_out,     // address present level
  output logic mem_cfg_ok_out,           // config sufficient level
  output logic radio_reset_n_out,        // radio reset pin
  output logic baseband_reset_n_out,     // baseband reset pin
  output logic host_cmd_valid_out,       // command strobe
  output logic [1:0] host_cmd_out,       // command code
  output logic [2:0] host_cmd_data_out   // command data
);
  logic [3:0] cnt_r;
  initial begin
    cnt_r = 4'h0;
    mem_load_done_out = 1'b0;
    radio_reset_n_out = 1'b0;
    baseband_reset_n_out = 1'b0;
    host_cmd_valid_out = 1'b0;
    host_cmd_out = 2'h0;
    host_cmd_data_out = 3'h0;
  end
  // one done pulse per requested block, after a chosen delay
  always @(posedge mclk_in) begin
    mem_load_done_out <= 1'b0;
    if (mem_load_req_in === 1'b1 && !mem_load_done_out) begin
      if (cnt_r == mem_dly_in) begin
        mem_load_done_out <= 1'b1;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end else begin
      cnt_r <= 4'h0;
    end
  end
  // status levels mean nothing outside a load, so show the wrong value there
  assign mem_addr_present_out = (mem_load_req_in === 1'b1) ? addr_ok_in : !addr_ok_in;
  assign mem_cfg_ok_out = (mem_load_req_in === 1'b1) ? cfg_ok_in : !cfg_ok_in;
  task automatic hold_reset();
    @(posedge mclk_in);
    radio_reset_n_out <= 1'b0;
    baseband_reset_n_out <= 1'b0;
  endtask
  task automatic power_up();
    @(posedge mclk_in);
    radio_reset_n_out <= 1'b1;
    repeat (RST_GAP) @(posedge mclk_in);
    baseband_reset_n_out <= 1'b1;
  endtask
  task automatic send(input logic [1:0] cmd, input logic [2:0] data);
    @(posedge mclk_in);
    host_cmd_valid_out <= 1'b1;
    host_cmd_out <= cmd;
    host_cmd_data_out <= data;
    @(posedge mclk_in);
    host_cmd_valid_out <= 1'b0;
    host_cmd_out <= ~cmd;
    host_cmd_data_out <= ~data;
  endtask
endmodule
`default_nettype wire

// ===== sol_loader_tb.sv
// testbench: walks the loader through each startup path and judges the result
// assumes sol_host_model as memory engine and host, AHB-Lite master in here
`timescale 1ns/100ps
`default_nettype none
module sol_loader_tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel_in = 1'b0;
  logic hwrite_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [31:0] hwdata_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h2;
  logic [4:0] option_pin_in = 5'h0;
  logic addr_ok = 1'b0;
  logic cfg_ok = 1'b0;
  logic [3:0] mem_dly = 4'h0;
  logic [31:0] hrdata_out, rd;
  logic hreadyout_out, hresp_out, irq_out, radio_reset_n_in, baseband_reset_n_in, clk_seen;
  logic [5:0] strap_pull_en_out, strap_pull_up_out;
  logic mem_load_req_out, mem_load_done_in, mem_addr_present_in, mem_cfg_ok_in, host_cmd_valid_in;
  logic [1:0] mem_load_block_out, mem_kind_out, host_cmd_in, uart_baud_out, baud_seen;
  logic [2:0] host_cmd_data_in;
  logic await_init_out, store_addr_write_out, uart_retune_out, uart_clk13_out, core_start_out;
  logic core_q = 1'b0;
  logic ret_q = 1'b0;
  logic [1:0] loads[$];
  int fails = 0;
  int n_tests = 0;
  int n_await = 0;
  int n_addrw = 0;
  always #20 mclk_in = ~mclk_in;
  sol_loader sol_loader_inst (.mclk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
    .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .irq_out,
    .radio_reset_n_in, .baseband_reset_n_in, .option_pin_in, .strap_pull_en_out, .strap_pull_up_out,
    .mem_load_req_out, .mem_load_block_out, .mem_kind_out, .mem_load_done_in, .mem_addr_present_in,
    .mem_cfg_ok_in, .host_cmd_valid_in, .host_cmd_in, .host_cmd_data_in, .await_init_out,
    .store_addr_write_out, .uart_retune_out, .uart_clk13_out, .uart_baud_out, .core_start_out);
  sol_host_model sol_host_model_inst (.mclk_in, .mem_load_req_in(mem_load_req_out), .mem_dly_in(mem_dly),
    .addr_ok_in(addr_ok), .cfg_ok_in(cfg_ok), .mem_load_done_out(mem_load_done_in),
    .mem_addr_present_out(mem_addr_present_in), .mem_cfg_ok_out(mem_cfg_ok_in),
    .radio_reset_n_out(radio_reset_n_in), .baseband_reset_n_out(baseband_reset_n_in),
    .host_cmd_valid_out(host_cmd_valid_in), .host_cmd_out(host_cmd_in), .host_cmd_data_out(host_cmd_data_in));
  // event counters and the retune settings seen at the pulse
  always @(posedge mclk_in) begin
    if (await_init_out === 1'b1) n_await++;
    if (store_addr_write_out === 1'b1) n_addrw++;
    if (mem_load_req_out === 1'b1 && mem_load_done_in === 1'b1) loads.push_back(mem_load_block_out);
    if (uart_retune_out === 1'b1) begin
      clk_seen = uart_clk13_out;
      baud_seen = uart_baud_out;
    end
    if (core_start_out === 1'b1 && core_q !== 1'b1 && ret_q !== 1'b1) begin
      fails++;
      $display("BAD core_start_order exp 0 got 1");
    end
    core_q <= core_start_out;
    ret_q <= uart_retune_out;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge mclk_in);
    hsel_in <= 1'b1;
    htrans_in <= sol_pkg::HTRANS_NONSEQ;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    r = hrdata_out;
  endtask
  task automatic wait_core();
    for (int k = 0; k < 60 && core_start_out !== 1'b1; k++) @(posedge mclk_in);
  endtask
  task automatic boot(input logic [4:0] op, input logic a, input logic c, input logic [3:0] d,
    input logic [2:0] sc);
    sol_host_model_inst.hold_reset();
    option_pin_in <= op;
    addr_ok <= a;
    cfg_ok <= c;
    mem_dly <= d;
    ahb(1'b1, sol_pkg::OFS_STORE_CFG, {29'h0, sc}, rd);
    ahb(1'b1, sol_pkg::OFS_IRQ_STAT, 32'h7, rd);
    repeat (4) @(posedge mclk_in);
    chk("pull_en", 32'h3F, strap_pull_en_out);
    chk("pull_up", 32'h20, strap_pull_up_out);
    n_await = 0;
    n_addrw = 0;
    loads.delete();
    clk_seen = 1'hX;
    baud_seen = 2'hX;
    sol_host_model_inst.power_up();
    for (int k = 0; k < 8 && strap_pull_en_out !== 6'h0; k++) @(posedge mclk_in);
    chk("pull_off", 32'h0, strap_pull_en_out);
    option_pin_in <= ~op;
    ahb(1'b0, sol_pkg::OFS_OPTIONS, 32'h0, rd);
    chk("options", {27'h0, op}, rd);
  endtask
  task automatic t_reset();
    ahb(1'b0, sol_pkg::OFS_IRQ_MASK, 32'h0, rd);
    chk("mask_rst", {29'h0, sol_pkg::IRQ_MASK_RST}, rd);
    ahb(1'b0, sol_pkg::OFS_STORE_CFG, 32'h0, rd);
    chk("cfg_rst", {29'h0, sol_pkg::STORE_CFG_RST}, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, hresp_out);
    $display("t_reset done");
  endtask
  task automatic t_fixed();
    logic [4:0] codes[3] = '{5'h05, 5'h03, 5'h07};
    for (int i = 0; i < 3; i++) begin
      boot(codes[i], 1'b1, 1'b1, 4'h0, 3'h0);
      repeat (30) @(posedge mclk_in);
      chk("await", 32'h1, n_await);
      chk("loads", 32'h0, loads.size());
      chk("kind", 32'h0, mem_kind_out);
      sol_host_model_inst.send(2'h1, 3'h0);
      sol_host_model_inst.send(2'h2, 3'h0);
      repeat (4) @(posedge mclk_in);
      chk("core_wait", 32'h0, core_start_out);
      sol_host_model_inst.send(2'h3, 3'h0);
      wait_core();
      chk("core", 32'h1, core_start_out);
      chk("clk13", 32'h1, clk_seen);
      chk("baud", i + 1, baud_seen);
    end
    $display("t_fixed done");
  endtask
  task automatic t_mem_ok();
    boot(5'h18, 1'b1, 1'b1, 4'h3, 3'h3);
    wait_core();
    chk("core", 32'h1, core_start_out);
    chk("await", 32'h0, n_await);
    chk("n_loads", 32'h3, loads.size());
    for (int i = 0; i < 3; i++) chk("load_blk", i, loads[i]);
    chk("kind", 32'h3, mem_kind_out);
    chk("clk13", 32'h0, clk_seen);
    chk("baud", 32'h3, baud_seen);
    ahb(1'b0, sol_pkg::OFS_STATE, 32'h0, rd);
    chk("state", 32'h00000E00, rd);
    $display("t_mem_ok done");
  endtask
  task automatic t_noaddr();
    boot(5'h11, 1'b0, 1'b1, 4'h0, 3'h6);
    repeat (40) @(posedge mclk_in);
    chk("core_wait", 32'h0, core_start_out);
    chk("await", 32'h1, n_await);
    chk("kind", 32'h2, mem_kind_out);
    chk("n_loads", 32'h3, loads.size());
    sol_host_model_inst.send(2'h2, 3'h0);
    repeat (3) @(posedge mclk_in);
    chk("addr_write", 32'h1, n_addrw);
    sol_host_model_inst.send(2'h3, 3'h0);
    wait_core();
    chk("clk13", 32'h1, clk_seen);
    chk("baud", 32'h2, baud_seen);
    $display("t_noaddr done");
  endtask
  task automatic t_detect();
    boot(5'h0A, 1'b1, 1'b1, 4'h0, 3'h0);
    repeat (30) @(posedge mclk_in);
    chk("kind", 32'h1, mem_kind_out);
    chk("loads", 32'h0, loads.size());
    chk("await", 32'h1, n_await);
    ahb(1'b0, sol_pkg::OFS_IRQ_STAT, 32'h0, rd);
    chk("irq_stat", 32'h5, rd);
    chk("irq_masked", 32'h0, irq_out);
    ahb(1'b1, sol_pkg::OFS_IRQ_MASK, 32'h4, rd);
    @(posedge mclk_in);
    chk("irq_on", 32'h1, irq_out);
    ahb(1'b1, sol_pkg::OFS_IRQ_STAT, 32'h4, rd);
    @(posedge mclk_in);
    chk("irq_off", 32'h0, irq_out);
    ahb(1'b0, sol_pkg::OFS_IRQ_STAT, 32'h0, rd);
    chk("irq_w1c", 32'h1, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    sol_host_model_inst.send(2'h1, 3'h5);
    sol_host_model_inst.send(2'h3, 3'h0);
    wait_core();
    chk("clk13", 32'h1, clk_seen);
    chk("baud", 32'h1, baud_seen);
    $display("t_detect done");
  endtask
  task automatic results();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_fixed();
    t_mem_ok();
    t_noaddr();
    t_detect();
    results();
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    results();
  end
endmodule
`default_nettype wire
